/* core/buck_reg_pkg.sv */
`default_nettype none

package buck_reg_pkg;

  // register offsets on the link
  localparam logic [7:0] OFS_SP_LOW  = 8'h00;
  localparam logic [7:0] OFS_SP_HIGH = 8'h01;
  localparam logic [7:0] OFS_CONTROL = 8'h02;
  localparam logic [7:0] OFS_IDENT1  = 8'h03;
  localparam logic [7:0] OFS_IDENT2  = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h05;

  // setpoint register layout
  typedef struct packed {
    logic       soft_enable;
    logic [6:0] code;
  } setpoint_t;

  // control register layout, reserved and self-clearing bits kept in place
  typedef struct packed {
    logic       discharge;
    logic [2:0] ramp_code;
    logic       rsvd;
    logic       soft_reset;
    logic [1:0] mode;
  } control_t;

  // status register layout
  typedef struct packed {
    logic       regulation_reached;
    logic [3:0] rsvd_hi;
    logic       reset_seen;
    logic [1:0] rsvd_lo;
  } status_t;

  // link-side register request
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } link_cmd_t;

  localparam logic [6:0] SP_CODE_RESET = 7'h50;  // plain default, 1.100 V
  localparam logic       SP_EN_RESET   = 1'h1;
  localparam control_t   CTRL_RESET    = control_t'(8'h82);

  // identity codes, values arbitrary
  localparam logic [2:0] MAKER_CODE_DEF = 3'h5;
  localparam logic [3:0] CHIP_TYPE_DEF  = 4'h3;
  localparam logic [3:0] REV_CODE_DEF   = 4'h2;

  // output voltage in microvolts and ramp rate in hundredths of mV/us
  localparam logic [20:0] VOUT_BASE_UV   = 21'h0927C0;  // 600000 uV
  localparam logic [20:0] VOUT_STEP_UV   = 21'h00186A;  // 6250 uV
  localparam logic [12:0] RAMP_FAST_X100 = 13'h1900;    // 64.00 mV/us

endpackage

`default_nettype wire

/* core/buck_regulator_register_bank.sv */
`default_nettype none

module buck_regulator_register_bank #(
  parameter logic [2:0] MAKER_CODE = buck_reg_pkg::MAKER_CODE_DEF,  // arbitrary value
  parameter logic [3:0] CHIP_TYPE  = buck_reg_pkg::CHIP_TYPE_DEF,   // arbitrary value
  parameter logic [3:0] REV_CODE   = buck_reg_pkg::REV_CODE_DEF     // arbitrary value
) (
  input  wire logic                    i_clk,                 // core clock, 20 MHz
  input  wire logic                    i_rst_b,               // async reset, active low
  input  wire logic                    i_link_clk,            // clock of the link engine
  input  wire logic                    i_link_req,            // request strobe, link domain
  input  wire buck_reg_pkg::link_cmd_t i_link_cmd,            // write flag, offset, data
  output logic                         o_link_busy,           // request in flight
  output logic                         o_link_done,           // one-cycle answer pulse
  output logic [7:0]                   o_link_rdata,          // read answer
  input  wire logic                    i_voltage_choice_pin,  // setpoint select pin
  input  wire logic                    i_hw_enable_pin,       // hardware enable pin
  input  wire logic                    i_softstart_done,      // soft-start finished
  output logic                         o_regulator_on,        // regulator running
  output logic [6:0]                   o_setpoint_code,       // applied voltage code
  output logic [20:0]                  o_vout_uv,             // target output, microvolts
  output logic                         o_discharge_on,        // pull-down active
  output logic [2:0]                   o_ramp_code,           // upward ramp code
  output logic [12:0]                  o_ramp_rate_x100,      // ramp, 0.01 mV/us units
  output logic                         o_forced_pwm           // 1 forced PWM, 0 auto
);
  import buck_reg_pkg::*;

  // target voltage from a setpoint code
  function automatic logic [20:0] code_to_uv(input logic [6:0] code);
    logic [20:0] prod;
    prod = VOUT_STEP_UV * {14'h0000, code};
    return VOUT_BASE_UV + prod;
  endfunction

  // ramp rate from a ramp code, halving per step
  function automatic logic [12:0] code_to_ramp(input logic [2:0] code);
    return RAMP_FAST_X100 >> code;
  endfunction

  // ------------------------------------------------------------------
  // link domain state
  // ------------------------------------------------------------------
  typedef struct packed {
    link_cmd_t  cmd;       // held stable while busy, read by the core domain
    logic       req_tgl;   // flips once per request taken
    logic       ack_s1;
    logic       ack_s2;
    logic       ack_d;
    logic       done;
    logic [7:0] rdata;
  } link_state_t;

  // ------------------------------------------------------------------
  // core domain state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       req_s1;
    logic       req_s2;
    logic       req_d;
    logic       sel_s1;
    logic       sel_s2;
    logic       hwen_s1;
    logic       hwen_s2;
    logic       ss_s1;
    logic       ss_s2;
    setpoint_t  sp_low;
    setpoint_t  sp_high;
    control_t   ctrl;
    logic       reset_seen;
    logic [7:0] rdata;
    logic       ack_tgl;
    logic       on;
    logic [6:0] code;
    logic [20:0] vout_uv;
    logic       discharge_on;
    logic [2:0] ramp_code;
    logic [12:0] ramp_rate;
    logic       forced_pwm;
  } core_state_t;

  link_state_t lk_r;
  link_state_t lk_nxt;
  core_state_t cr_r;
  core_state_t cr_nxt;

  logic link_take;
  logic ack_edge;

  // a new request is refused while the previous one has not come back
  assign o_link_busy = lk_r.req_tgl ^ lk_r.ack_d;
  assign link_take   = i_link_req & ~o_link_busy;
  assign ack_edge    = lk_r.ack_s2 ^ lk_r.ack_d;

  // link side: capture the request, then wait for the core's toggle back
  always_comb begin
    lk_nxt        = lk_r;
    lk_nxt.ack_s1 = cr_r.ack_tgl;
    lk_nxt.ack_s2 = lk_r.ack_s1;
    lk_nxt.ack_d  = lk_r.ack_s2;
    lk_nxt.done   = ack_edge;
    if (link_take) begin
      lk_nxt.cmd     = i_link_cmd;
      lk_nxt.req_tgl = ~lk_r.req_tgl;
    end
    // core read data is stable here: it changed in the same core cycle as the ack toggle
    if (ack_edge) begin
      lk_nxt.rdata = cr_r.rdata;
    end
  end

  // link side registers
  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  assign o_link_done  = lk_r.done;
  assign o_link_rdata = lk_r.rdata;

  // ------------------------------------------------------------------
  // core side
  // ------------------------------------------------------------------
  logic      req_edge;
  setpoint_t sp_sel;
  logic      mode_bit;
  logic      running;
  status_t   status_img;
  logic [7:0] read_img;
  control_t  ctrl_wr;
  logic      soft_reset_hit;
  logic      status_read;

  assign req_edge = cr_r.req_s2 ^ cr_r.req_d;

  // pin-selected setpoint and mode bit
  always_comb begin
    if (cr_r.sel_s2) begin
      sp_sel   = cr_r.sp_high;
      mode_bit = cr_r.ctrl.mode[1];
    end else begin
      sp_sel   = cr_r.sp_low;
      mode_bit = cr_r.ctrl.mode[0];
    end
  end

  // hardware pin gates, soft bit decides while the pin is high
  assign running = cr_r.hwen_s2 & sp_sel.soft_enable;

  // status image; reserved fields tied low
  always_comb begin
    status_img                    = '0;
    status_img.regulation_reached = running & cr_r.ss_s2;
    status_img.reset_seen         = cr_r.reset_seen;
  end

  // ------------------------------------------------------------------
  // shared decode helpers
  // ------------------------------------------------------------------
  // handshake between the two clocks, as the core sees it:
  //   the link side flips req_tgl and freezes its command word
  //   two core flops carry the toggle, a third marks the edge
  //   the core acts on the edge, loads rdata and flips ack_tgl
  //   the link side syncs ack_tgl back and only then drops busy
  // a host that ignores busy corrupts nothing in flight: its strobe is simply refused
  // the round trip costs a few cycles of each clock, which a register
  // bank behind a slow serial link can well afford

  // offset match; reads and writes use the same compare
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // control write image: reserved bit dropped, reset bit never stored
  function automatic control_t ctrl_from_write(input logic [7:0] wdata);
    control_t c;
    c            = control_t'(wdata);
    c.rsvd       = 1'h0;
    c.soft_reset = 1'h0;
    return c;
  endfunction

  // reserved identity fields
  localparam logic       IDENT1_RSVD = 1'h0;
  localparam logic [3:0] IDENT2_RSVD = 4'h0;

  // identity images; fixed at build time, writes never reach them
  function automatic logic [7:0] maker_chip_image();
    return {MAKER_CODE, IDENT1_RSVD, CHIP_TYPE};
  endfunction

  function automatic logic [7:0] die_revision_image();
    return {IDENT2_RSVD, REV_CODE};
  endfunction

  // setpoint default: soft enable set, plain voltage code
  localparam setpoint_t SP_RESET = '{soft_enable: SP_EN_RESET, code: SP_CODE_RESET};

  // power-on image of the core state; outputs match the defaults at once
  function automatic core_state_t core_reset_value();
    core_state_t v;
    v              = '0;
    v.sp_low       = SP_RESET;
    v.sp_high      = SP_RESET;
    v.ctrl         = CTRL_RESET;
    v.code         = SP_CODE_RESET;
    v.vout_uv      = code_to_uv(SP_CODE_RESET);
    v.discharge_on = CTRL_RESET.discharge;
    v.ramp_code    = CTRL_RESET.ramp_code;
    v.ramp_rate    = code_to_ramp(CTRL_RESET.ramp_code);
    v.forced_pwm   = CTRL_RESET.mode[0];
    return v;
  endfunction

  // the async reset branch loads only this constant
  localparam core_state_t CORE_RESET = core_reset_value();

  // ------------------------------------------------------------------
  // command seen by the core
  // ------------------------------------------------------------------
  link_cmd_t cmd_seen;
  control_t  ctrl_raw;
  logic      wr_hit;
  logic      rd_hit;

  // the link side holds its command word until the toggle comes back, so
  // the word is settled long before the synchronised edge reaches here
  assign cmd_seen = lk_r.cmd;
  assign ctrl_raw = control_t'(cmd_seen.wdata);
  assign wr_hit   = req_edge & cmd_seen.we;
  assign rd_hit   = req_edge & ~cmd_seen.we;

  // control write image and the self-clearing reset request
  assign ctrl_wr        = ctrl_from_write(cmd_seen.wdata);
  assign soft_reset_hit = wr_hit & addr_hit(cmd_seen.addr, OFS_CONTROL)
                          & ctrl_raw.soft_reset;

  // a status read clears the reset flag after its image is taken
  assign status_read = rd_hit & addr_hit(cmd_seen.addr, OFS_STATUS);

  // read image by offset; unmapped offsets read as zero
  always_comb begin
    control_t ctrl_img;
    ctrl_img            = cr_r.ctrl;
    ctrl_img.rsvd       = 1'h0;
    ctrl_img.soft_reset = 1'h0;
    if (addr_hit(cmd_seen.addr, OFS_SP_LOW)) begin
      read_img = cr_r.sp_low;
    end else if (addr_hit(cmd_seen.addr, OFS_SP_HIGH)) begin
      read_img = cr_r.sp_high;
    end else if (addr_hit(cmd_seen.addr, OFS_CONTROL)) begin
      read_img = ctrl_img;
    end else if (addr_hit(cmd_seen.addr, OFS_IDENT1)) begin
      read_img = maker_chip_image();
    end else if (addr_hit(cmd_seen.addr, OFS_IDENT2)) begin
      read_img = die_revision_image();
    end else if (addr_hit(cmd_seen.addr, OFS_STATUS)) begin
      read_img = status_img;
    end else begin
      read_img = 8'h00;
    end
  end

  // core next state
  always_comb begin
    cr_nxt = cr_r;
    // request toggle: two flops, then one more for the edge
    cr_nxt.req_s1  = lk_r.req_tgl;
    cr_nxt.req_s2  = cr_r.req_s1;
    cr_nxt.req_d   = cr_r.req_s2;
    // pins are asynchronous to the core clock: two flops each
    cr_nxt.sel_s1  = i_voltage_choice_pin;
    cr_nxt.sel_s2  = cr_r.sel_s1;
    cr_nxt.hwen_s1 = i_hw_enable_pin;
    cr_nxt.hwen_s2 = cr_r.hwen_s1;
    cr_nxt.ss_s1   = i_softstart_done;
    cr_nxt.ss_s2   = cr_r.ss_s1;
    // register writes; identity, status and unmapped offsets take none
    if (wr_hit) begin
      if (addr_hit(cmd_seen.addr, OFS_SP_LOW)) begin
        cr_nxt.sp_low = setpoint_t'(cmd_seen.wdata);
      end else if (addr_hit(cmd_seen.addr, OFS_SP_HIGH)) begin
        cr_nxt.sp_high = setpoint_t'(cmd_seen.wdata);
      end else if (addr_hit(cmd_seen.addr, OFS_CONTROL)) begin
        cr_nxt.ctrl = ctrl_wr;
      end else begin
        cr_nxt.ctrl = cr_r.ctrl;
      end
    end
    // soft reset overrides the write that carried it
    if (soft_reset_hit) begin
      cr_nxt.sp_low  = SP_RESET;
      cr_nxt.sp_high = SP_RESET;
      cr_nxt.ctrl    = CTRL_RESET;
    end
    // reset flag: a set in the same cycle as a clear wins
    if (soft_reset_hit) begin
      cr_nxt.reset_seen = 1'h1;
    end else if (status_read) begin
      cr_nxt.reset_seen = 1'h0;
    end
    // answer: read data settles in the same cycle as the ack toggle
    if (req_edge) begin
      cr_nxt.rdata   = read_img;
      cr_nxt.ack_tgl = ~cr_r.ack_tgl;
    end
    // outputs lag the synchronised pins by one register; the loop is slow
    cr_nxt.on           = running;
    cr_nxt.code         = sp_sel.code;
    cr_nxt.vout_uv      = code_to_uv(sp_sel.code);
    cr_nxt.discharge_on = ~running & cr_r.ctrl.discharge;
    cr_nxt.ramp_code    = cr_r.ctrl.ramp_code;
    cr_nxt.ramp_rate    = code_to_ramp(cr_r.ctrl.ramp_code);
    cr_nxt.forced_pwm   = mode_bit;
  end

  // core registers; reset loads only the constant image
  // the link side shares this reset, so both sides start with equal toggles
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cr_r <= CORE_RESET;
    end else begin
      cr_r <= cr_nxt;
    end
  end

  // outputs straight from the core registers
  // limitation: the pull-down follows the enable at once; any delay the
  // analog side needs before discharging is its own business
  assign o_regulator_on   = cr_r.on;
  assign o_setpoint_code  = cr_r.code;
  assign o_vout_uv        = cr_r.vout_uv;
  assign o_discharge_on   = cr_r.discharge_on;
  assign o_ramp_code      = cr_r.ramp_code;
  assign o_ramp_rate_x100 = cr_r.ramp_rate;
  assign o_forced_pwm     = cr_r.forced_pwm;

endmodule

`default_nettype wire

/* verif/buck_bank_checker.sv */
`default_nettype none
module buck_bank_checker
  import buck_reg_pkg::*;
(
  input wire logic        i_clk,                // core clock
  input wire logic        i_rst_b,              // reset
  input wire logic        i_hw_enable_pin,      // enable pin
  input wire logic        i_voltage_choice_pin, // select pin
  input wire logic        o_regulator_on,       // running
  input wire logic [6:0]  o_setpoint_code,      // code
  input wire logic [20:0] o_vout_uv,            // target
  input wire logic        o_discharge_on,       // pull-down
  input wire logic [2:0]  o_ramp_code,          // ramp code
  input wire logic [12:0] o_ramp_rate_x100,     // ramp rate
  input wire logic        o_forced_pwm          // mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // four samples low cover two synchroniser flops and the output register
  sequence s_pin_off;
    !i_hw_enable_pin [*4];
  endsequence
  a_hw_enable_gate: assert property (s_pin_off |-> !o_regulator_on)
    else $error("on with enable pin low");
  a_on_needs_pin: assert property (o_regulator_on |-> $past(i_hw_enable_pin, 3))
    else $error("on without enable pin");
  a_discharge_off: assert property (o_discharge_on |-> !o_regulator_on)
    else $error("pull-down while running");
  a_vout_formula: assert property (
    o_vout_uv == VOUT_BASE_UV + 21'(o_setpoint_code) * VOUT_STEP_UV) else $error("vout wrong");
  a_ramp_table: assert property (o_ramp_rate_x100 == RAMP_FAST_X100 >> o_ramp_code)
    else $error("ramp rate wrong");
  // first sample after release still shows register defaults
  a_reset_setpoint: assert property ($rose(i_rst_b) |->
    o_setpoint_code == SP_CODE_RESET && o_ramp_code == 3'h0) else $error("bad defaults");
  a_reset_mode: assert property ($rose(i_rst_b) |-> o_forced_pwm == i_voltage_choice_pin)
    else $error("bad default mode");
  a_reset_discharge: assert property ($rose(i_rst_b) && !o_regulator_on |-> o_discharge_on)
    else $error("bad default discharge");
endmodule
bind buck_regulator_register_bank buck_bank_checker u_buck_bank_checker (.*);
`default_nettype wire

/* verif/link_host_model.sv */
`default_nettype none
module link_host_model
  import buck_reg_pkg::*;
(
  input  wire logic       i_link_clk, // link clock
  input  wire logic       i_busy,     // in flight
  input  wire logic       i_done,     // answer pulse
  input  wire logic [7:0] i_rdata,    // read answer
  output var  logic       o_req,      // strobe
  output var  link_cmd_t  o_cmd,      // request fields
  output var  logic       o_timeout   // no answer
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_req = 1'b0;
  initial o_cmd = '0;
  initial o_timeout = 1'b0;
  // hold the command until done is sampled, then scramble released fields
  task automatic xfer(input logic we, input logic [7:0] a, d, output logic [7:0] q);
    int n;
    n = 0;
    do begin
      @(posedge i_link_clk);
      n++;
    end while (i_busy !== 1'b0 && n < 100);
    o_req <= 1'b1;
    o_cmd <= '{we, a, d};
    // busy was low, so the next edge takes the request; drop the strobe there
    @(posedge i_link_clk);
    o_req <= 1'b0;
    do begin
      @(posedge i_link_clk);
      n++;
    end while (i_done !== 1'b1 && n < 200);
    q = i_rdata;
    if (n >= 200) o_timeout = 1'b1;
    o_cmd <= '{~we, ~a, ~d};
  endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import buck_reg_pkg::*;
  logic clk = 1'b0, lclk = 1'b0, rst_b = 1'b0, pin = 1'b0, en = 1'b0, ss = 1'b0;
  logic req, busy, done, on, dis, pwm, tout;
  logic [7:0] rdata, q;
  logic [6:0] code;
  logic [20:0] vout;
  logic [2:0] rcode;
  logic [12:0] rate;
  link_cmd_t cmd;
  int miscompares = 0, checks = 0;
  // link clock starts 3 ns late; its rising edges still meet the core clock's every 300 ns
  always #25 clk = ~clk;
  initial begin
    #3;
    forever #6 lclk = ~lclk;
  end
  buck_regulator_register_bank u_buck_regulator_register_bank (.i_clk(clk), .i_rst_b(rst_b),
    .i_link_clk(lclk), .i_link_req(req), .i_link_cmd(cmd), .o_link_busy(busy),
    .o_link_done(done), .o_link_rdata(rdata), .i_voltage_choice_pin(pin),
    .i_hw_enable_pin(en), .i_softstart_done(ss), .o_regulator_on(on),
    .o_setpoint_code(code), .o_vout_uv(vout), .o_discharge_on(dis), .o_ramp_code(rcode),
    .o_ramp_rate_x100(rate), .o_forced_pwm(pwm));
  link_host_model u_link_host_model (.i_link_clk(lclk), .i_busy(busy), .i_done(done),
    .i_rdata(rdata), .o_req(req), .o_cmd(cmd), .o_timeout(tout));
  task automatic wrap_up;
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [20:0] got, exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  // a lost answer ends the run at once
  task automatic xf(input logic we, input logic [7:0] a, d);
    u_link_host_model.xfer(we, a, d, q);
    if (tout !== 1'b0) begin
      miscompares++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    xf(1'b1, a, d);
    repeat (8) @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [20:0] e);
    xf(1'b0, a, 8'h00);
    cmp(q, e);
  endtask
  task automatic drive(input logic p, e);
    @(posedge clk);
    pin <= p;
    en <= e;
    ss <= e;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(OFS_SP_HIGH, 8'hD0);
    rdc(OFS_CONTROL, 8'h82);
    xf(1'b0, OFS_STATUS, 8'h00);
    xf(1'b0, 8'h06, 8'h00);
    wr(OFS_IDENT1, 8'hFF);
    wr(OFS_IDENT2, 8'hFF);
    rdc(OFS_IDENT1, {MAKER_CODE_DEF, 1'b0, CHIP_TYPE_DEF});
    rdc(OFS_IDENT2, {4'h0, REV_CODE_DEF});
    wr(OFS_SP_LOW, 8'hFF);
    cmp(vout, 21'h154456);
    drive(1'b1, 1'b0);
    cmp(code, SP_CODE_RESET);
    cmp(pwm, 1'b1);
    for (int k = 0; k < 8; k++) begin
      wr(OFS_CONTROL, {1'b1, 3'(k), 4'hA});
      cmp(rate, RAMP_FAST_X100 >> k);
      rdc(OFS_CONTROL, {1'b1, 3'(k), 4'h2});
    end
    wr(OFS_CONTROL, 8'h01);
    cmp({pwm, dis}, 2'h0);
    drive(1'b0, 1'b1);
    cmp({pwm, on}, 2'h3);
    rdc(OFS_STATUS, 8'h80);
    wr(OFS_SP_LOW, 8'h7F);
    wr(OFS_CONTROL, 8'h80);
    cmp({on, dis}, 2'h1);
    wr(OFS_CONTROL, 8'h04);
    rdc(OFS_CONTROL, 8'h82);
    rdc(OFS_SP_LOW, 8'hD0);
    rdc(OFS_STATUS, 8'h84);
    rdc(OFS_STATUS, 8'h80);
    drive(1'b0, 1'b0);
    cmp({on, dis}, 2'h1);
    wrap_up();
  end
endmodule
`default_nettype wire
